// file: hw/bst_tap.sv
// boundary-scan test access port of the memory device
`timescale 1ns/1ns
module bst_tap #(
  parameter logic [31:0] ID_CODE = bst_pkg::ID_CODE_DEFAULT
) (
  input  wire logic                     clock_i,
  input  wire logic                     rst_i,
  input  wire logic                     tck_i,
  input  wire logic                     tms_i,
  input  wire logic                     tdi_i,
  input  wire logic                     trst_n_i,
  input  wire logic [bst_pkg::BSR_W-1:0] pin_ring_i,
  output logic                          tdo_o,
  output logic                          tdo_oe_o,
  output logic [bst_pkg::BSR_W-1:0]     bsr_out_o,
  output bst_pkg::bst_ctrl_s            ctrl_o
);

  // combined asynchronous reset of the test domain
  logic tap_rst;
  assign tap_rst = rst_i | ~trst_n_i;

  // standard next-state table, used by the controller
  function automatic bst_pkg::bst_state_e step(input bst_pkg::bst_state_e s,
                                               input logic m);
    case (s)
      bst_pkg::ST_RESET:    step = m ? bst_pkg::ST_RESET   : bst_pkg::ST_IDLE;
      bst_pkg::ST_IDLE:     step = m ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_DR:   step = m ? bst_pkg::ST_SEL_IR  : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR:   step = m ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_SHIFT_DR: step = m ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_EXIT1_DR: step = m ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_PAUSE_DR: step = m ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_EXIT2_DR: step = m ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_UPD_DR:   step = m ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_IR:   step = m ? bst_pkg::ST_RESET   : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR:   step = m ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_SHIFT_IR: step = m ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_EXIT1_IR: step = m ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_PAUSE_IR: step = m ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_EXIT2_IR: step = m ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_UPD_IR:   step = m ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
      default:              step = bst_pkg::ST_RESET;
    endcase
  endfunction

  // instruction decode for the boundary chain, used in several places
  function automatic logic uses_bsr(input logic [2:0] ins);
    uses_bsr = (ins == bst_pkg::INS_EXTEST) || (ins == bst_pkg::INS_SAMPLE_PL) ||
               (ins == bst_pkg::INS_SAMPLE_Z);
  endfunction

  // rising-edge state of the test domain
  bst_pkg::bst_state_e        state_reg, state_next;
  logic [bst_pkg::IR_W-1:0]   ir_sh_reg, ir_sh_next;
  logic [bst_pkg::IR_W-1:0]   ir_reg, ir_next;
  logic                       byp_reg, byp_next;
  logic [bst_pkg::ID_W-1:0]   id_reg, id_next;
  logic [bst_pkg::BSR_W-1:0]  bsr_reg, bsr_next;
  logic [bst_pkg::BSR_W-1:0]  upd_reg, upd_next;

  // mode select, data in and test reset pins are pulled high on the pad,
  // so a floating pin arrives here as one and parks the controller
  // in reset after five edges; nothing extra is needed in logic.

  // next values for controller and scan registers
  always_comb begin
    state_next = step(state_reg, tms_i);
    ir_sh_next = ir_sh_reg;
    ir_next    = ir_reg;
    byp_next   = byp_reg;
    id_next    = id_reg;
    bsr_next   = bsr_reg;
    upd_next   = upd_reg;
    case (state_reg)
      bst_pkg::ST_RESET: begin
        ir_next  = bst_pkg::IR_RESET;
        upd_next = bst_pkg::BSR_RESET;
      end
      bst_pkg::ST_CAP_IR: begin
        ir_sh_next = {ir_reg[2], bst_pkg::IR_CAPTURE_LOW[1:0]};
      end
      bst_pkg::ST_SHIFT_IR: begin
        ir_sh_next = {tdi_i, ir_sh_reg[2:1]};
      end
      bst_pkg::ST_UPD_IR: begin
        ir_next = ir_sh_reg;
        if (ir_sh_reg == bst_pkg::INS_BYPASS) begin
          byp_next = 1'b0;
        end
      end
      bst_pkg::ST_CAP_DR: begin
        if (ir_reg == bst_pkg::INS_IDCODE) begin
          id_next = ID_CODE;
        end else if (uses_bsr(ir_reg)) begin
          bsr_next = pin_ring_i;
        end else begin
          byp_next = 1'b0;
        end
      end
      bst_pkg::ST_SHIFT_DR: begin
        // only the selected register moves
        if (ir_reg == bst_pkg::INS_IDCODE) begin
          id_next = {tdi_i, id_reg[bst_pkg::ID_W-1:1]};
        end else if (uses_bsr(ir_reg)) begin
          bsr_next = {tdi_i, bsr_reg[bst_pkg::BSR_W-1:1]};
        end else begin
          byp_next = tdi_i;
        end
      end
      bst_pkg::ST_UPD_DR: begin
        if (uses_bsr(ir_reg)) begin
          upd_next = bsr_reg;
        end
      end
      default: begin
        ir_next = ir_reg;
      end
    endcase
  end

  // rising edge registers; async clear by pin or system reset
  always_ff @(posedge tck_i or posedge tap_rst) begin
    if (tap_rst) begin
      state_reg <= bst_pkg::ST_RESET;
      ir_sh_reg <= bst_pkg::IR_RESET;
      ir_reg    <= bst_pkg::IR_RESET;
      byp_reg   <= 1'b0;
      id_reg    <= bst_pkg::ID_CODE_DEFAULT;
      bsr_reg   <= bst_pkg::BSR_RESET;
      upd_reg   <= bst_pkg::BSR_RESET;
    end else begin
      state_reg <= state_next;
      ir_sh_reg <= ir_sh_next;
      ir_reg    <= ir_next;
      byp_reg   <= byp_next;
      id_reg    <= id_next;
      bsr_reg   <= bsr_next;
      upd_reg   <= upd_next;
    end
  end

  // serial output selection and enable
  logic tdo_next, tdo_oe_next;
  logic tdo_reg,  tdo_oe_reg;
  always_comb begin
    tdo_oe_next = (state_reg == bst_pkg::ST_SHIFT_DR) ||
                  (state_reg == bst_pkg::ST_SHIFT_IR);
    if (state_reg == bst_pkg::ST_SHIFT_IR) begin
      tdo_next = ir_sh_reg[0];
    end else if (ir_reg == bst_pkg::INS_IDCODE) begin
      tdo_next = id_reg[0];
    end else if (uses_bsr(ir_reg)) begin
      tdo_next = bsr_reg[0];
    end else begin
      tdo_next = byp_reg;
    end
  end

  // falling edge output stage keeps data out stable across the rising edge
  always_ff @(negedge tck_i or posedge tap_rst) begin
    if (tap_rst) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg    <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
    end
  end

  assign tdo_o    = tdo_reg;
  assign tdo_oe_o = tdo_oe_reg;

  // test-domain control word; changes only after instruction or data update, or on reset
  bst_pkg::bst_ctrl_s ctrl_tck;
  always_comb begin
    ctrl_tck.test_mode = uses_bsr(ir_reg) && (ir_reg != bst_pkg::INS_SAMPLE_PL);
    ctrl_tck.odt_off   = ctrl_tck.test_mode;
    ctrl_tck.drive_a   = (ir_reg == bst_pkg::INS_EXTEST) &&
                         upd_reg[bst_pkg::BSR_OE_A_POS];
    ctrl_tck.drive_b   = (ir_reg == bst_pkg::INS_EXTEST) &&
                         upd_reg[bst_pkg::BSR_OE_B_POS];
    ctrl_tck.float_out = (ir_reg == bst_pkg::INS_SAMPLE_Z);
  end

  // level crossing into the memory clock; two flops per bit. the control
  // bits move only at instruction or data update or on reset, so skew between bits
  // lasts at most one memory cycle. these flops are reset by rst_i only, not by trst_n_i.
  bst_pkg::bst_ctrl_s ctrl_s1_reg, ctrl_s2_reg;
  logic [bst_pkg::BSR_W-1:0] bo_s1_reg, bo_s2_reg;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_s1_reg <= '0;
      ctrl_s2_reg <= '0;
      bo_s1_reg   <= bst_pkg::BSR_RESET;
      bo_s2_reg   <= bst_pkg::BSR_RESET;
    end else begin
      ctrl_s1_reg <= ctrl_tck;
      ctrl_s2_reg <= ctrl_s1_reg;
      bo_s1_reg   <= upd_reg;
      bo_s2_reg   <= bo_s1_reg;
    end
  end

  assign ctrl_o    = ctrl_s2_reg;
  assign bsr_out_o = bo_s2_reg;

endmodule

// file: hw/bst_pkg.sv
// package for the boundary-scan test access port
package bst_pkg;

  localparam int IR_W  = 3;
  localparam int ID_W  = 32;
  localparam int BSR_W = 64;
  localparam int BSR_OE_B_POS = 49;
  localparam int BSR_OE_A_POS = 50;
  localparam int TLR_ONES = 5;
  localparam logic [2:0] IR_CAPTURE_LOW = 3'h1;

  // instruction codes; identification is the reset instruction
  localparam logic [2:0] INS_EXTEST    = 3'h0;
  localparam logic [2:0] INS_IDCODE    = 3'h1;
  localparam logic [2:0] INS_SAMPLE_Z  = 3'h2;
  localparam logic [2:0] INS_SAMPLE_PL = 3'h4;
  localparam logic [2:0] INS_BYPASS    = 3'h7;
  localparam logic [2:0] IR_RESET      = INS_IDCODE;

  // identification word, arbitrary value
  localparam logic [31:0] ID_CODE_DEFAULT = 32'h0000_0001;
  localparam logic [BSR_W-1:0] BSR_RESET  = 64'h0000_0000_0000_0000;

  typedef enum logic [3:0] {
    ST_RESET      = 4'h0,
    ST_IDLE       = 4'h1,
    ST_SEL_DR     = 4'h2,
    ST_CAP_DR     = 4'h3,
    ST_SHIFT_DR   = 4'h4,
    ST_EXIT1_DR   = 4'h5,
    ST_PAUSE_DR   = 4'h6,
    ST_EXIT2_DR   = 4'h7,
    ST_UPD_DR     = 4'h8,
    ST_SEL_IR     = 4'h9,
    ST_CAP_IR     = 4'hA,
    ST_SHIFT_IR   = 4'hB,
    ST_EXIT1_IR   = 4'hC,
    ST_PAUSE_IR   = 4'hD,
    ST_EXIT2_IR   = 4'hE,
    ST_UPD_IR     = 4'hF
  } bst_state_e;

  // controls handed to the memory core
  typedef struct packed {
    logic test_mode;
    logic odt_off;
    logic drive_a;
    logic drive_b;
    logic float_out;
  } bst_ctrl_s;

endpackage

// file: dv/bst_tap_checker.sv
// concurrent checks on the test access port pins
`timescale 1ns/1ns
module bst_tap_checker (
  input wire logic                      clock_i,
  input wire logic                      rst_i,
  input wire logic                      tck_i,
  input wire logic                      tms_i,
  input wire logic                      trst_n_i,
  input wire logic                      tdo_o,
  input wire logic                      tdo_oe_o,
  input wire logic [bst_pkg::BSR_W-1:0] bsr_out_o,
  input wire bst_pkg::bst_ctrl_s        ctrl_o
);
  // pin timing seen from the fast clock; tck edges never share its edges
  chk_tdo_fall_only: assert property (@(posedge clock_i) disable iff (rst_i || !trst_n_i)
    !($past(tck_i) && !tck_i) |-> $stable(tdo_o)) else $error("tdo moved off a falling edge");
  chk_oe_fall_only: assert property (@(posedge clock_i) disable iff (rst_i || !trst_n_i)
    !($past(tck_i) && !tck_i) |-> $stable(tdo_oe_o)) else $error("oe moved off a falling edge");
  // a high mode select never lands in a shift state
  chk_oe_after_high: assert property (@(posedge tck_i) disable iff (rst_i || !trst_n_i)
    $past(tms_i) |-> !tdo_oe_o) else $error("tdo driven outside shift");
  // 1,1,0 always ends in idle or capture
  chk_oe_idle_path: assert property (@(posedge tck_i) disable iff (rst_i || !trst_n_i)
    $past(tms_i, 3) && $past(tms_i, 2) && !$past(tms_i) |-> !tdo_oe_o)
    else $error("tdo driven after idle path");
  chk_rst_release: assert property (@(posedge clock_i) disable iff (rst_i || !trst_n_i)
    $fell(rst_i) |-> !tdo_oe_o && !tdo_o) else $error("tdo not quiet after power-up reset");
  // sync flops need two edges to show the reset
  chk_trst_clears: assert property (@(posedge clock_i) disable iff (rst_i)
    (!trst_n_i)[*4] |-> ctrl_o == '0 && bsr_out_o == '0) else $error("test reset not seen");
  chk_odt_follows: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_o.odt_off == ctrl_o.test_mode) else $error("termination not off in test mode");
  chk_float_excl: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_o.float_out |-> ctrl_o.test_mode && !ctrl_o.drive_a && !ctrl_o.drive_b)
    else $error("bus driven while floating");
  cov_oe_rise: cover property (@(posedge tck_i) $rose(tdo_oe_o));
  cov_drive: cover property (@(posedge clock_i) ctrl_o.drive_a && ctrl_o.drive_b);
  cov_float: cover property (@(posedge clock_i) ctrl_o.float_out);
  cov_trst: cover property (@(posedge clock_i) $fell(trst_n_i));
endmodule
bind bst_tap bst_tap_checker chk_u (.clock_i(clock_i), .rst_i(rst_i), .tck_i(tck_i),
  .tms_i(tms_i), .trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .bsr_out_o(bsr_out_o), .ctrl_o(ctrl_o));

// file: dv/bst_jtag_host.sv
// boundary-scan controller model facing the test port
`timescale 1ns/1ns
module bst_jtag_host (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  // clock parked low between frames, other pins at their pull-up level
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // one 64 ns test-clock period; tdo read at the rising edge
  task automatic step(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #32 tck_o = 1'b1;
    q = tdo_oe_i ? tdo_i : ~tdo_i; // released line reads as garbage
    #32 tck_o = 1'b0;
  endtask
endmodule

// file: dv/tb.sv
// self-checking bench for the test access port
`timescale 1ns/1ns
module tb;
  logic               clock_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               trst_n_i = 1'b1;
  logic               tck, tms, tdi, tdo, tdo_oe, q;
  logic [63:0]        ring = 64'h0123_4567_89AB_CDEF;
  logic [63:0]        din = 64'h0006_0000_0000_A5A5;
  logic [63:0]        bsr, d;
  bst_pkg::bst_ctrl_s ctrl;
  int                 failures = 0;
  int                 check_count = 0;
  always #2 clock_i = ~clock_i;
  bst_tap dut_u (.clock_i(clock_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n_i), .pin_ring_i(ring), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .bsr_out_o(bsr), .ctrl_o(ctrl));
  bst_jtag_host host_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
    .tdo_oe_i(tdo_oe));
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  // idle to shift, n bits lsb first, then update and back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] di,
                      output logic [63:0] dout);
    dout = '0;
    host_u.step(1'b1, 1'b1, q);
    if (ir) host_u.step(1'b1, 1'b1, q);
    host_u.step(1'b0, 1'b1, q);
    host_u.step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      host_u.step(i == n - 1, di[i], q);
      dout[i] = q;
    end
    host_u.step(1'b1, 1'b1, q);
    host_u.step(1'b0, 1'b1, q);
  endtask
  task automatic set_ir(input logic [2:0] code, input logic [2:0] cap);
    scan(1'b1, 3, {61'h0, code}, d);
    check("ir capture", {61'h0, cap}, d);
  endtask
  task automatic test_idcode;
    check("oe after reset", 64'h0, {63'h0, tdo_oe});
    scan(1'b0, 32, 64'h0, d);
    check("id word", {32'h0, bst_pkg::ID_CODE_DEFAULT}, d);
    $display("idcode test done");
  endtask
  task automatic test_bypass;
    set_ir(bst_pkg::INS_BYPASS, 3'h1);
    scan(1'b0, 4, 64'hB, d);
    check("bypass path", 64'h6, d);
    $display("bypass test done");
  endtask
  task automatic test_boundary;
    set_ir(bst_pkg::INS_SAMPLE_PL, 3'h5);
    scan(1'b0, 64, din, d);
    check("ring capture", ring, d);
    set_ir(bst_pkg::INS_EXTEST, 3'h5);
    check("ctrl extest", 64'h1E, {59'h0, ctrl});
    check("update latches", din, bsr);
    set_ir(bst_pkg::INS_SAMPLE_Z, 3'h1);
    check("ctrl float", 64'h19, {59'h0, ctrl});
    ring = ~ring;
    scan(1'b0, 64, din, d);
    check("ring capture z", ring, d);
    $display("boundary test done");
  endtask
  task automatic test_reset;
    for (int i = 0; i < 5; i++) begin
      host_u.step(1'b1, 1'b1, q);
    end
    host_u.step(1'b0, 1'b1, q);
    check("ctrl after ones", 64'h0, {59'h0, ctrl});
    check("latches after ones", 64'h0, bsr);
    set_ir(bst_pkg::INS_EXTEST, 3'h1);
    check("ctrl extest off", 64'h18, {59'h0, ctrl});
    @(posedge clock_i);
    #1 trst_n_i = 1'b0;
    repeat (8) @(posedge clock_i);
    check("ctrl after trst", 64'h0, {59'h0, ctrl});
    #1 trst_n_i = 1'b1;
    host_u.step(1'b0, 1'b1, q);
    $display("reset test done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard: runs out well past the longest sequence
  initial begin
    repeat (60000) @(posedge clock_i);
    failures++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge clock_i);
    #1 rst_i = 1'b0;
    host_u.step(1'b0, 1'b1, q);
    test_idcode;
    test_bypass;
    test_boundary;
    test_reset;
    end_sim;
  end
endmodule
